/* design/bgi_map.svh */
// Purpose: Offsets, field positions, reset values of the buffer geometry bank
// Assumes: Register index times four gives the AXI byte address
// Notes:   Definitions only
`ifndef BGI_MAP_SVH
`define BGI_MAP_SVH

// Register indices
`define BGI_IDX_VERSION      16'hf002
`define BGI_IDX_DATA_BUF     16'hf003
`define BGI_IDX_BOOT_BUF     16'hf004
`define BGI_IDX_BUF_COUNT    16'hf005
`define BGI_IDX_CELL_TYPE    16'hf006
`define BGI_IDX_BLOCK_SEL    16'hf100

// Reset and fixed values
`define BGI_RST_DATA_BUF     16'h0800
`define BGI_RST_BOOT_BUF     16'h0200
`define BGI_RST_BUF_COUNT    16'h0201
`define BGI_RST_CELL_TYPE    16'h0000
`define BGI_RST_BLOCK_SEL    16'h0000

// Cell type codes
`define BGI_CELL_SLC         16'h0000
`define BGI_CELL_MLC         16'h0001

// Field positions
`define BGI_CNT_DATA_LSB     8
`define BGI_CNT_BOOT_LSB     0
`define BGI_CNT_FIELD_W      8
`define BGI_BLK_SEL_W        9
`define BGI_REG_W            16

// Bus geometry and responses
`define BGI_ADDR_W           18
`define BGI_RESP_OKAY        2'b00
`define BGI_RESP_SLVERR      2'b10

`endif

/* design/bgi_pkg.sv */
// Purpose: Types shared by the buffer geometry bank
// Assumes: bgi_map.svh supplies widths
// Notes:   AXI4-Lite channels travel as packed structs
`default_nettype none
`include "bgi_map.svh"

package bgi_pkg;

    typedef struct packed {
        logic [`BGI_ADDR_W-1:0] addr;
        logic [2:0]             prot;
    } bgi_addr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
    } bgi_wdata_t;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  resp;
    } bgi_rdata_t;

    typedef enum logic [2:0] {
        BGI_SEL_VERSION,
        BGI_SEL_DATA_BUF,
        BGI_SEL_BOOT_BUF,
        BGI_SEL_BUF_COUNT,
        BGI_SEL_CELL_TYPE,
        BGI_SEL_BLOCK_SEL,
        BGI_SEL_NONE
    } bgi_sel_t;

endpackage : bgi_pkg
`default_nettype wire

/* design/bgi_block_sel_reg.sv */
// Purpose: Writable target block select register
// Assumes: Write strobe is a one-cycle pulse from the bus slave
// Notes:   Only the low block bits are stored; the rest read as zero
`timescale 1ns/1ps
`default_nettype none
`include "bgi_map.svh"

module bgi_block_sel_reg
    import bgi_pkg::*;
#(
    parameter int BLK_W = `BGI_BLK_SEL_W
)
(
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Write side
    input  wire logic             i_we,
    input  wire logic [15:0]      i_wdata,
    input  wire logic [1:0]       i_strb,
    // Stored value
    output var  logic [BLK_W-1:0] o_value
);

    logic [BLK_W-1:0] value_q;
    logic [BLK_W-1:0] value_d;
    logic [15:0]      merged;

    always_comb
    begin
        merged = {{(16-BLK_W){1'b0}}, value_q};
        if (i_strb[0])
        begin
            merged[7:0] = i_wdata[7:0];
        end
        if (i_strb[1])
        begin
            merged[15:8] = i_wdata[15:8];
        end
        value_d = i_we ? merged[BLK_W-1:0] : value_q;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            value_q <= BLK_W'(`BGI_RST_BLOCK_SEL);
        end
        else
        begin
            value_q <= value_d;
        end
    end

    assign o_value = value_q;

endmodule : bgi_block_sel_reg
`default_nettype wire

/* design/bgi_info_regs.sv */
// Purpose: Buffer geometry and array technology bank on AXI4-Lite
// Assumes: Bus master on I_REF_CLK, one write and one read at a time
// Notes:   Register index times four is the byte address
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "bgi_map.svh"

module bgi_info_regs
    import bgi_pkg::*;
#(
    parameter logic [15:0] VERSION_CODE   = 16'h0001, // Arbitrary value
    parameter logic [15:0] DATA_BUF_WORDS = `BGI_RST_DATA_BUF,
    parameter logic [15:0] BOOT_BUF_WORDS = `BGI_RST_BOOT_BUF,
    parameter logic [7:0]  DATA_BUF_COUNT = 8'h02,
    parameter logic [7:0]  BOOT_BUF_COUNT = 8'h01,
    parameter logic [15:0] CELL_TYPE      = `BGI_CELL_SLC,
    parameter int          BLK_W          = `BGI_BLK_SEL_W
)
(
    // Clock and reset
    input  wire logic             I_REF_CLK,
    input  wire logic             I_RST,
    // Write address channel
    input  wire logic             I_AW_VALID,
    output var  logic             O_AW_READY,
    input  wire bgi_addr_t        I_AW,
    // Write data channel
    input  wire logic             I_W_VALID,
    output var  logic             O_W_READY,
    input  wire bgi_wdata_t       I_W,
    // Write response channel
    output var  logic             O_B_VALID,
    output var  logic [1:0]       O_B_RESP,
    input  wire logic             I_B_READY,
    // Read address channel
    input  wire logic             I_AR_VALID,
    output var  logic             O_AR_READY,
    input  wire bgi_addr_t        I_AR,
    // Read data channel
    output var  logic             O_R_VALID,
    output var  bgi_rdata_t       O_R,
    input  wire logic             I_R_READY,
    // Block select to the array sequencer
    output var  logic [BLK_W-1:0] O_FLASH_BLOCK_SELECT
);

    // Shared address decode; misaligned words count as unmapped
    function automatic bgi_sel_t decode(input logic [`BGI_ADDR_W-1:0] addr);
        logic [15:0] idx;
        idx = addr[`BGI_ADDR_W-1:2];
        if (addr[1:0] != 2'b00)
        begin
            return BGI_SEL_NONE;
        end
        unique case (idx)
            `BGI_IDX_VERSION:   return BGI_SEL_VERSION;
            `BGI_IDX_DATA_BUF:  return BGI_SEL_DATA_BUF;
            `BGI_IDX_BOOT_BUF:  return BGI_SEL_BOOT_BUF;
            `BGI_IDX_BUF_COUNT: return BGI_SEL_BUF_COUNT;
            `BGI_IDX_CELL_TYPE: return BGI_SEL_CELL_TYPE;
            `BGI_IDX_BLOCK_SEL: return BGI_SEL_BLOCK_SEL;
            default:            return BGI_SEL_NONE;
        endcase
    endfunction : decode

    // Write path state
    logic       aw_full_q;
    logic       aw_full_d;
    logic       w_full_q;
    logic       w_full_d;
    logic       awready_q;
    logic       awready_d;
    logic       wready_q;
    logic       wready_d;
    logic       bvalid_q;
    logic       bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    bgi_sel_t   wr_sel_q;
    bgi_sel_t   wr_sel_d;
    bgi_wdata_t w_q;
    bgi_wdata_t w_d;
    logic       do_write;
    logic       blk_we;

    // Read path state
    logic       ar_full_q;
    logic       ar_full_d;
    logic       arready_q;
    logic       arready_d;
    logic       rvalid_q;
    logic       rvalid_d;
    bgi_rdata_t r_q;
    bgi_rdata_t r_d;
    bgi_sel_t   rd_sel_q;
    bgi_sel_t   rd_sel_d;
    logic       do_read;
    logic [15:0] rd_word;

    logic [BLK_W-1:0] blk_sel;

    // Write side: address and data taken in either order
    always_comb
    begin
        do_write  = aw_full_q && w_full_q && !bvalid_q;
        blk_we    = do_write && (wr_sel_q == BGI_SEL_BLOCK_SEL);
        wr_sel_d  = wr_sel_q;
        w_d       = w_q;
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        if (I_AW_VALID && awready_q)
        begin
            aw_full_d = 1'b1;
            wr_sel_d  = decode(I_AW.addr);
        end
        else if (do_write)
        begin
            aw_full_d = 1'b0;
        end
        if (I_W_VALID && wready_q)
        begin
            w_full_d = 1'b1;
            w_d      = I_W;
        end
        else if (do_write)
        begin
            w_full_d = 1'b0;
        end
        awready_d = !aw_full_d;
        wready_d  = !w_full_d;
        bvalid_d  = do_write || (bvalid_q && !I_B_READY);
        bresp_d   = bresp_q;
        if (do_write)
        begin
            // Read-only targets answer OKAY and keep their value
            bresp_d = (wr_sel_q == BGI_SEL_NONE) ? `BGI_RESP_SLVERR : `BGI_RESP_OKAY;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `BGI_RESP_OKAY;
            wr_sel_q  <= BGI_SEL_NONE;
            w_q       <= '0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            wr_sel_q  <= wr_sel_d;
            w_q       <= w_d;
        end
    end

    bgi_block_sel_reg #(
        .BLK_W   (BLK_W)
    ) u_block_sel (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RST),
        .i_we    (blk_we),
        .i_wdata (w_q.data[15:0]),
        .i_strb  (w_q.strb[1:0]),
        .o_value (blk_sel)
    );

    // Read mux; fixed values live here so writes cannot reach them
    always_comb
    begin
        // Unused enum code reads zero, no latch
        rd_word = 16'h0000;
        unique case (rd_sel_q)
            BGI_SEL_VERSION:   rd_word = VERSION_CODE;
            BGI_SEL_DATA_BUF:  rd_word = DATA_BUF_WORDS;
            BGI_SEL_BOOT_BUF:  rd_word = BOOT_BUF_WORDS;
            BGI_SEL_BUF_COUNT: rd_word = {DATA_BUF_COUNT, BOOT_BUF_COUNT};
            BGI_SEL_CELL_TYPE: rd_word = CELL_TYPE;
            BGI_SEL_BLOCK_SEL: rd_word = {{(16-BLK_W){1'b0}}, blk_sel};
            BGI_SEL_NONE:      rd_word = 16'h0000;
        endcase
    end

    // Read side: one outstanding read, answer one cycle after capture
    always_comb
    begin
        do_read   = ar_full_q && !rvalid_q;
        rd_sel_d  = rd_sel_q;
        ar_full_d = ar_full_q;
        if (I_AR_VALID && arready_q)
        begin
            ar_full_d = 1'b1;
            rd_sel_d  = decode(I_AR.addr);
        end
        else if (do_read)
        begin
            ar_full_d = 1'b0;
        end
        rvalid_d = do_read || (rvalid_q && !I_R_READY);
        r_d      = r_q;
        if (do_read)
        begin
            r_d.data = {16'h0000, rd_word};
            r_d.resp = (rd_sel_q == BGI_SEL_NONE) ? `BGI_RESP_SLVERR : `BGI_RESP_OKAY;
        end
        arready_d = !ar_full_d && !rvalid_d;
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ar_full_q <= 1'b0;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            r_q       <= '0;
            rd_sel_q  <= BGI_SEL_NONE;
        end
        else
        begin
            ar_full_q <= ar_full_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            r_q       <= r_d;
            rd_sel_q  <= rd_sel_d;
        end
    end

    assign O_AW_READY           = awready_q;
    assign O_W_READY            = wready_q;
    assign O_B_VALID            = bvalid_q;
    assign O_B_RESP             = bresp_q;
    assign O_AR_READY           = arready_q;
    assign O_R_VALID            = rvalid_q;
    assign O_R                  = r_q;
    assign O_FLASH_BLOCK_SELECT = blk_sel;

    // Checks
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    sequence s_read_of(bgi_sel_t sel);
        do_read && (rd_sel_q == sel);
    endsequence

    sequence s_full_block_write;
        do_write && (wr_sel_q == BGI_SEL_BLOCK_SEL) && (w_q.strb[1:0] == 2'b11);
    endsequence

    a_data_buf_read:
    assert property (s_read_of(BGI_SEL_DATA_BUF) |=> O_R_VALID && O_R.data == 32'h0000_0800)
        else $error("Data buffer size read wrong");

    a_boot_buf_read:
    assert property (s_read_of(BGI_SEL_BOOT_BUF) |=> O_R_VALID && O_R.data == 32'h0000_0200)
        else $error("Boot buffer size read wrong");

    a_buf_count_read:
    assert property (s_read_of(BGI_SEL_BUF_COUNT) |=> O_R.data == 32'h0000_0201
                     && O_R.resp == `BGI_RESP_OKAY)
        else $error("Buffer count read wrong");

    a_cell_type_read:
    assert property (s_read_of(BGI_SEL_CELL_TYPE) |=> O_R.data == 32'h0000_0000
                     && O_R_VALID)
        else $error("Cell type read wrong");

    a_block_sel_write:
    assert property (s_full_block_write |=> O_FLASH_BLOCK_SELECT == $past(w_q.data[8:0])
                     && O_B_VALID)
        else $error("Block select not written");

    a_block_sel_readback:
    assert property (s_read_of(BGI_SEL_BLOCK_SEL) |=> O_R.data[31:9] == 23'h0
                     && O_R.data[8:0] == $past(O_FLASH_BLOCK_SELECT))
        else $error("Block select readback wrong");

    a_version_read:
    assert property (s_read_of(BGI_SEL_VERSION) |=> O_R.data == {16'h0000, VERSION_CODE})
        else $error("Version read wrong");

    a_ro_write_ignored:
    assert property (do_write && wr_sel_q != BGI_SEL_BLOCK_SEL
                     |=> $stable(O_FLASH_BLOCK_SELECT) && O_B_VALID)
        else $error("Read-only write changed state");

    a_resp_held:
    assert property (O_B_VALID && !I_B_READY |=> O_B_VALID && $stable(O_B_RESP))
        else $error("Write response dropped");

endmodule : bgi_info_regs
`default_nettype wire

/* tb/bgi_host_model.sv */
// Purpose: Host processor model on the AXI4-Lite register port
// Assumes: Tasks are called only after reset has been released
// Notes:   Released address and data lines show inverted values
`timescale 1ns/1ps
`default_nettype none
`include "bgi_map.svh"

module bgi_host_model
    import bgi_pkg::*;
(
    // Clock
    input  wire logic       i_clk,
    // Write channels
    output var  logic       o_aw_valid,
    input  wire logic       i_aw_ready,
    output var  bgi_addr_t  o_aw,
    output var  logic       o_w_valid,
    input  wire logic       i_w_ready,
    output var  bgi_wdata_t o_w,
    input  wire logic       i_b_valid,
    input  wire logic [1:0] i_b_resp,
    output var  logic       o_b_ready,
    // Read channels
    output var  logic       o_ar_valid,
    input  wire logic       i_ar_ready,
    output var  bgi_addr_t  o_ar,
    input  wire logic       i_r_valid,
    input  wire bgi_rdata_t i_r,
    output var  logic       o_r_ready
);
    initial
    begin
        {o_aw_valid, o_w_valid, o_b_ready, o_ar_valid, o_r_ready} = 5'h00;
        o_aw = '0;
        o_w  = '0;
        o_ar = '0;
    end

    // Address and data offered together, each released once taken
    task automatic write_word(input logic [17:0] addr, input logic [31:0] data,
                              input logic [3:0] strb, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge i_clk);
        o_aw_valid <= 1'b1;
        o_aw       <= '{addr: addr, prot: 3'h0};
        o_w_valid  <= 1'b1;
        o_w        <= '{data: data, strb: strb};
        o_b_ready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge i_clk);
            if (!aw_done && i_aw_ready)
            begin
                aw_done = 1'b1;
                o_aw_valid <= 1'b0;
                o_aw       <= ~o_aw;
            end
            if (!w_done && i_w_ready)
            begin
                w_done = 1'b1;
                o_w_valid <= 1'b0;
                o_w       <= ~o_w;
            end
        end
        do @(posedge i_clk); while (i_b_valid !== 1'b1);
        resp = i_b_resp;
        o_b_ready <= 1'b0;
    endtask : write_word

    task automatic read_word(input logic [17:0] addr, output logic [31:0] data,
                             output logic [1:0] resp);
        @(posedge i_clk);
        o_ar_valid <= 1'b1;
        o_ar       <= '{addr: addr, prot: 3'h0};
        o_r_ready  <= 1'b1;
        do @(posedge i_clk); while (i_ar_ready !== 1'b1);
        o_ar_valid <= 1'b0;
        o_ar       <= ~o_ar;
        do @(posedge i_clk); while (i_r_valid !== 1'b1);
        data = i_r.data;
        resp = i_r.resp;
        o_r_ready <= 1'b0;
    endtask : read_word
endmodule : bgi_host_model
`default_nettype wire

/* tb/buffer_geometry_info_registers_tb.sv */
// Purpose: Self-checking bench for the buffer geometry bank
// Assumes: Default parameters, 10 MHz clock
// Notes:   Version read first, then table rows, then version write and mid-run reset
`timescale 1ns/1ps
`default_nettype none
`include "bgi_map.svh"

`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end

module buffer_geometry_info_registers_tb
    import bgi_pkg::*;
;
    typedef struct packed {
        logic [17:0] addr;
        logic        wr;
        logic [31:0] wdata;
        logic [3:0]  strb;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bgi_row_t;

    // Read-only reads and writes first, then strobe lanes, then bad addresses, then a data buffer reread
    localparam bgi_row_t ROWS [13] = '{
        '{18'h3c00c, 1'b0, 32'h0, 4'h0, 2'h0, 32'h0000_0800, 2'h0},
        '{18'h3c00c, 1'b1, 32'hffff, 4'hf, 2'h0, 32'h0000_0800, 2'h0},
        '{18'h3c010, 1'b1, 32'h1234, 4'hf, 2'h0, 32'h0000_0200, 2'h0},
        '{18'h3c014, 1'b1, 32'hffff, 4'hf, 2'h0, 32'h0000_0201, 2'h0},
        '{18'h3c018, 1'b1, 32'h0001, 4'hf, 2'h0, 32'h0000_0000, 2'h0},
        '{18'h3c400, 1'b0, 32'h0, 4'h0, 2'h0, 32'h0000_0000, 2'h0},
        '{18'h3c400, 1'b1, 32'hffff_ffff, 4'hf, 2'h0, 32'h0000_01ff, 2'h0},
        '{18'h3c400, 1'b1, 32'h0, 4'h1, 2'h0, 32'h0000_0100, 2'h0},
        '{18'h3c400, 1'b1, 32'habcd, 4'h3, 2'h0, 32'h0000_01cd, 2'h0},
        '{18'h3c400, 1'b1, 32'h0, 4'h2, 2'h0, 32'h0000_00cd, 2'h0},
        '{18'h3c01c, 1'b1, 32'hffff, 4'hf, 2'h2, 32'h0, 2'h2},
        '{18'h3c00d, 1'b1, 32'hffff, 4'hf, 2'h2, 32'h0, 2'h2},
        '{18'h3c00c, 1'b0, 32'h0, 4'h0, 2'h0, 32'h0000_0800, 2'h0}
    };

    logic       i_ref_clk;
    logic       i_rst;
    logic       i_aw_valid, o_aw_ready, i_w_valid, o_w_ready, o_b_valid, i_b_ready;
    logic       i_ar_valid, o_ar_ready, o_r_valid, i_r_ready;
    logic [1:0] o_b_resp;
    bgi_addr_t  i_aw, i_ar;
    bgi_wdata_t i_w;
    bgi_rdata_t o_r;
    logic [8:0] o_flash_block_select;
    logic [31:0] rd, ver;
    logic [1:0] resp;
    int         num_errors, n_compared;
    int         cycles = 0;

    bgi_info_regs dut (.I_REF_CLK(i_ref_clk), .I_RST(i_rst),
        .I_AW_VALID(i_aw_valid), .O_AW_READY(o_aw_ready), .I_AW(i_aw),
        .I_W_VALID(i_w_valid), .O_W_READY(o_w_ready), .I_W(i_w),
        .O_B_VALID(o_b_valid), .O_B_RESP(o_b_resp), .I_B_READY(i_b_ready),
        .I_AR_VALID(i_ar_valid), .O_AR_READY(o_ar_ready), .I_AR(i_ar),
        .O_R_VALID(o_r_valid), .O_R(o_r), .I_R_READY(i_r_ready),
        .O_FLASH_BLOCK_SELECT(o_flash_block_select));

    bgi_host_model host (.i_clk(i_ref_clk),
        .o_aw_valid(i_aw_valid), .i_aw_ready(o_aw_ready), .o_aw(i_aw),
        .o_w_valid(i_w_valid), .i_w_ready(o_w_ready), .o_w(i_w),
        .i_b_valid(o_b_valid), .i_b_resp(o_b_resp), .o_b_ready(i_b_ready),
        .o_ar_valid(i_ar_valid), .i_ar_ready(o_ar_ready), .o_ar(i_ar),
        .i_r_valid(o_r_valid), .i_r(o_r), .o_r_ready(i_r_ready));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    task automatic print_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // Whole run needs about 120 cycles
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    initial
    begin
        i_rst      = 1'b1;
        num_errors = 0;
        n_compared = 0;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        `CHK("block select at reset", 9'h000, o_flash_block_select)
        host.read_word(18'h3c008, ver, resp);
        `CHK("version resp", `BGI_RESP_OKAY, resp)
        foreach (ROWS[i])
        begin
            if (ROWS[i].wr)
            begin
                host.write_word(ROWS[i].addr, ROWS[i].wdata, ROWS[i].strb, resp);
                `CHK("write resp", ROWS[i].bresp, resp)
            end
            host.read_word(ROWS[i].addr, rd, resp);
            `CHK("read data", ROWS[i].rdata, rd)
            `CHK("read resp", ROWS[i].rresp, resp)
            if (ROWS[i].addr == 18'h3c400)
                `CHK("block select port", ROWS[i].rdata[8:0], o_flash_block_select)
        end
        // Version must not move under a write
        host.write_word(18'h3c008, ~ver, 4'hf, resp);
        `CHK("version write resp", `BGI_RESP_OKAY, resp)
        host.read_word(18'h3c008, rd, resp);
        `CHK("version after write", ver, rd)
        `CHK("version read resp", `BGI_RESP_OKAY, resp)
        // Reset in mid-run clears the block select
        i_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        `CHK("block select after reset", 9'h000, o_flash_block_select)
        host.read_word(18'h3c400, rd, resp);
        `CHK("block select read after reset", 32'h0000_0000, rd)
        host.read_word(18'h3c014, rd, resp);
        `CHK("counts after reset", 32'h0000_0201, rd)
        print_verdict();
    end
endmodule : buffer_geometry_info_registers_tb
`undef CHK
`default_nettype wire
